//--- core/csr_setpoint_regs.sv
// Two host-writable setpoint registers and the outputs they steer.
// Assumes the serial slave engine presents one-cycle write strobes and
// a combinational read address, all synchronous to mclk.
`timescale 1ns/1ps

module csr_setpoint_regs (
  input wire logic mclk,
  input wire logic rst,
  input wire logic wrStrobe,
  input wire logic rdStrobe,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] wrData,
  input wire logic chargePinAutoEnable,
  input wire logic charge2PinAutoEnable,
  input wire logic autoChargePinLow,
  input wire logic autoCharge2PinLow,
  output logic [7:0] rdData,
  output logic [3:0] boostVoltageCode,
  output logic boostDirectEnable,
  output logic [2:0] buckboostRefCode,
  output logic [2:0] buckARefCode,
  output logic [2:0] buckBRefCode,
  output logic chargeIndicatorPinOut,
  output logic chargeIndicatorPinOe,
  output logic charge2IndicatorPinOut,
  output logic charge2IndicatorPinOe
);
  logic [7:0] regBoost;
  logic [7:0] regInd;

  // Shared address decode; keeps the write ports and the register-level checks below on
  // one definition of each offset.
  function automatic logic addrHit(input logic [7:0] a,
      input logic [7:0] o);
    return a == o;
  endfunction

  // Each register takes a whole byte; no field is write-protected.
  always_ff @(posedge mclk) begin
    if (rst) begin
      regBoost <= csr_regs_pkg::RESET_BOOST;
    end else if (wrStrobe && addrHit(regAddr, csr_regs_pkg::OFFS_BOOST)) begin
      regBoost <= wrData;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      regInd <= csr_regs_pkg::RESET_IND;
    end else if (wrStrobe && addrHit(regAddr, csr_regs_pkg::OFFS_IND)) begin
      regInd <= wrData;
    end
  end

  // Unmapped addresses read as zero. A read beside a write to the same
  // offset returns the old contents, as the host expects of a byte bus.
  always_ff @(posedge mclk) begin
    if (rst) begin
      rdData <= 8'h00;
    end else if (rdStrobe) begin
      case (regAddr)
        csr_regs_pkg::OFFS_BOOST: rdData <= regBoost;
        csr_regs_pkg::OFFS_IND: rdData <= regInd;
        default: rdData <= 8'h00;
      endcase
    end
  end

  // Field outputs lag the register by one edge so that all outputs are
  // flopped; the pad of an open-drain pin only ever pulls low.
  always_ff @(posedge mclk) begin
    if (rst) begin
      boostVoltageCode <= csr_regs_pkg::RESET_BOOST[7:4];
      boostDirectEnable <= csr_regs_pkg::RESET_BOOST[3];
      buckboostRefCode <= csr_regs_pkg::RESET_BOOST[2:0];
      buckARefCode <= csr_regs_pkg::RESET_IND[6:4];
      buckBRefCode <= csr_regs_pkg::RESET_IND[2:0];
    end else begin
      boostVoltageCode <=
          regBoost[csr_regs_pkg::BOOST_CODE_LSB +: 4];
      boostDirectEnable <= regBoost[csr_regs_pkg::BOOST_EN_BIT];
      buckboostRefCode <= regBoost[csr_regs_pkg::BUCKBOOST_LSB +: 3];
      buckARefCode <= regInd[csr_regs_pkg::BUCK_A_LSB +: 3];
      buckBRefCode <= regInd[csr_regs_pkg::BUCK_B_LSB +: 3];
    end
  end

  // Output enable is low while the pin is pulled low. Out is held at zero
  // so that a pad wired the wrong way round can only ever sink current,
  // never fight the external pull-up. The automatic request is sampled
  // straight from its input, since inputs are synchronous to mclk.
  always_ff @(posedge mclk) begin
    if (rst) begin
      chargeIndicatorPinOut <= 1'b0;
      chargeIndicatorPinOe <= 1'b1;
      charge2IndicatorPinOut <= 1'b0;
      charge2IndicatorPinOe <= 1'b1;
    end else begin
      chargeIndicatorPinOut <= 1'b0;
      charge2IndicatorPinOut <= 1'b0;
      chargeIndicatorPinOe <= chargePinAutoEnable ? !autoChargePinLow
          : regInd[csr_regs_pkg::CHG_LEVEL_BIT];
      charge2IndicatorPinOe <= charge2PinAutoEnable ? !autoCharge2PinLow
          : regInd[csr_regs_pkg::CHARGE2_INDICATOR_PIN_LEVEL_BIT];
    end
  end

  a_boost_write_out: assert property (@(posedge mclk) disable iff (rst)
      wrStrobe && regAddr == csr_regs_pkg::OFFS_BOOST
      |=> ##1 boostVoltageCode == $past(wrData[7:4], 2))
    else $error("boost code did not follow write");
  a_boost_enable_out: assert property (@(posedge mclk) disable iff (rst)
      wrStrobe && regAddr == csr_regs_pkg::OFFS_BOOST
      |-> ##2 boostDirectEnable == $past(wrData[3], 2))
    else $error("direct enable did not follow write");
  a_buckboost_out: assert property (@(posedge mclk) disable iff (rst)
      wrStrobe && regAddr == csr_regs_pkg::OFFS_BOOST
      |-> ##2 buckboostRefCode == $past(wrData[2:0], 2))
    else $error("buck-boost code did not follow write");
  a_charge_pin_manual: assert property (@(posedge mclk) disable iff (rst)
      !chargePinAutoEnable |=> chargeIndicatorPinOe == $past(regInd[7])
      && !chargeIndicatorPinOut)
    else $error("charge pin not set by level bit");
  a_buck_a_out: assert property (@(posedge mclk) disable iff (rst)
      wrStrobe && regAddr == csr_regs_pkg::OFFS_IND
      |-> ##2 buckARefCode == $past(wrData[6:4], 2))
    else $error("step-down code did not follow write");
  a_read_back: assert property (@(posedge mclk) disable iff (rst)
      wrStrobe && regAddr == csr_regs_pkg::OFFS_IND ##1
      rdStrobe && !wrStrobe && regAddr == csr_regs_pkg::OFFS_IND
      |=> rdData == $past(wrData, 2))
    else $error("read did not return written value");
  a_charge2_manual: assert property (@(posedge mclk) disable iff (rst)
      !charge2PinAutoEnable |=> charge2IndicatorPinOe == $past(regInd[3])
      && !charge2IndicatorPinOut)
    else $error("charge pin 2 not set by level bit");
  a_reset_values: assert property (@(posedge mclk)
      $past(rst) |-> regBoost == csr_regs_pkg::RESET_BOOST
      && regInd == csr_regs_pkg::RESET_IND)
    else $error("reset values wrong");
  a_hold_value: assert property (@(posedge mclk) disable iff (rst)
      !wrStrobe |=> $stable(regBoost) && $stable(regInd))
    else $error("register changed without write");

  // Register-level checks: the pair must take every write at once and
  // give it back on a later read; a read in the same cycle as the write returns the old value.
  a_boost_reg_write: assert property (@(posedge mclk) disable iff (rst)
      wrStrobe && addrHit(regAddr, csr_regs_pkg::OFFS_BOOST)
      |=> regBoost == $past(wrData))
    else $error("boost register missed a write");
  a_ind_reg_write: assert property (@(posedge mclk) disable iff (rst)
      wrStrobe && addrHit(regAddr, csr_regs_pkg::OFFS_IND)
      |=> regInd == $past(wrData))
    else $error("indicator register missed a write");
  a_read_boost: assert property (@(posedge mclk) disable iff (rst)
      rdStrobe && addrHit(regAddr, csr_regs_pkg::OFFS_BOOST)
      |=> rdData == $past(regBoost))
    else $error("boost register read back wrong");
  a_read_ind: assert property (@(posedge mclk) disable iff (rst)
      rdStrobe && addrHit(regAddr, csr_regs_pkg::OFFS_IND)
      |=> rdData == $past(regInd))
    else $error("indicator register read back wrong");
  a_read_during_write: assert property (@(posedge mclk) disable iff (rst)
      rdStrobe && wrStrobe && addrHit(regAddr, csr_regs_pkg::OFFS_IND)
      |=> rdData == $past(regInd))
    else $error("read beside a write did not return the old value");
  a_read_unmapped: assert property (@(posedge mclk) disable iff (rst)
      rdStrobe && !addrHit(regAddr, csr_regs_pkg::OFFS_BOOST)
      && !addrHit(regAddr, csr_regs_pkg::OFFS_IND)
      |=> rdData == 8'h00)
    else $error("unmapped read returned data");
  a_read_hold: assert property (@(posedge mclk) disable iff (rst)
      !rdStrobe |=> $stable(rdData))
    else $error("read data moved without a read");

  // Pin and output checks. In automatic mode the status logic outside
  // owns the pin; the level bits only matter once it is switched off.
  a_charge_auto: assert property (@(posedge mclk) disable iff (rst)
      chargePinAutoEnable
      |=> chargeIndicatorPinOe == !$past(autoChargePinLow))
    else $error("charge pin ignored automatic request");
  a_charge2_auto: assert property (@(posedge mclk) disable iff (rst)
      charge2PinAutoEnable
      |=> charge2IndicatorPinOe == !$past(autoCharge2PinLow))
    else $error("charge pin 2 ignored automatic request");
  a_pins_never_high: assert property (@(posedge mclk) disable iff (rst)
      !chargeIndicatorPinOut && !charge2IndicatorPinOut)
    else $error("open-drain pin drove high");
  a_buck_b_out: assert property (@(posedge mclk) disable iff (rst)
      wrStrobe && regAddr == csr_regs_pkg::OFFS_IND
      |-> ##2 buckBRefCode == $past(wrData[2:0], 2))
    else $error("second step-down code did not follow write");
  a_fields_hold: assert property (@(posedge mclk) disable iff (rst)
      !wrStrobe ##1 !wrStrobe |=> $stable(boostVoltageCode)
      && $stable(buckboostRefCode) && $stable(buckARefCode))
    else $error("field output moved without a write");
  a_reset_outputs: assert property (@(posedge mclk)
      $past(rst) |-> rdData == 8'h00 && !boostDirectEnable
      && boostVoltageCode == csr_regs_pkg::RESET_BOOST[7:4]
      && buckboostRefCode == csr_regs_pkg::RESET_BOOST[2:0]
      && buckARefCode == csr_regs_pkg::RESET_IND[6:4]
      && buckBRefCode == csr_regs_pkg::RESET_IND[2:0]
      && chargeIndicatorPinOe && charge2IndicatorPinOe)
    else $error("outputs not at reset values");

  // Covers: the scenarios that must be seen at least once for the checks
  // above to mean anything.
  c_write_boost: cover property (@(posedge mclk)
      wrStrobe && regAddr == csr_regs_pkg::OFFS_BOOST);
  c_write_ind: cover property (@(posedge mclk)
      wrStrobe && regAddr == csr_regs_pkg::OFFS_IND);
  c_pin_low: cover property (@(posedge mclk) !chargeIndicatorPinOe);
  c_pin2_low: cover property (@(posedge mclk) !charge2IndicatorPinOe);
  c_read_ind: cover property (@(posedge mclk)
      rdStrobe && regAddr == csr_regs_pkg::OFFS_IND);
endmodule

//--- core/csr_regs_pkg.sv
// Constants for the converter setpoint register pair.
// Assumes an external serial slave engine supplies byte-wide accesses.
package csr_regs_pkg;
  localparam logic [7:0] OFFS_BOOST = 8'h04;
  localparam logic [7:0] OFFS_IND = 8'h05;
  localparam logic [7:0] RESET_BOOST = 8'ha4;
  localparam logic [7:0] RESET_IND = 8'hcc;
  localparam int BOOST_CODE_LSB = 4;
  localparam int BOOST_EN_BIT = 3;
  localparam int BUCKBOOST_LSB = 0;
  localparam int CHG_LEVEL_BIT = 7;
  localparam int BUCK_A_LSB = 4;
  localparam int CHARGE2_INDICATOR_PIN_LEVEL_BIT = 3;
  localparam int BUCK_B_LSB = 0;
endpackage

//--- verif/csr_pin_pullup.sv
// Pull-up model of one open-drain charge indicator line.
// Assumes Out and Oe come from the register block; Oe low drives.
`timescale 1ns/1ps
module csr_pin_pullup (
  input wire logic pinOut,
  input wire logic pinOe,
  output logic pinLevel
);
  // A released line floats up to the pull-up level.
  assign pinLevel = pinOe ? 1'b1 : pinOut;
endmodule

//--- verif/csr_testbench.sv
// Random register traffic checked against a behavioural register model.
// Assumes the register block and the pull-up model are compiled first.
`timescale 1ns/1ps
module testbench;
  logic mclk, rst, wrS, rdS, au1, au2, lo1, lo2, o1, e1, o2, e2, p1, p2, en;
  logic [7:0] ad, wd, rd, a;
  logic [3:0] bc;
  logic [2:0] bb, ba, bk;
  logic [31:0] seed = 32'h6f5b;
  int miscompares = 0, comparisons = 0;
  int regs [2] = '{8'ha4, 8'hcc};
  csr_setpoint_regs i_dut (.mclk(mclk), .rst(rst), .wrStrobe(wrS),
    .rdStrobe(rdS), .regAddr(ad), .wrData(wd), .chargePinAutoEnable(au1),
    .charge2PinAutoEnable(au2), .autoChargePinLow(lo1),
    .autoCharge2PinLow(lo2), .rdData(rd), .boostVoltageCode(bc),
    .boostDirectEnable(en), .buckboostRefCode(bb), .buckARefCode(ba),
    .buckBRefCode(bk), .chargeIndicatorPinOut(o1),
    .chargeIndicatorPinOe(e1), .charge2IndicatorPinOut(o2),
    .charge2IndicatorPinOe(e2));
  csr_pin_pullup i_pin1 (.pinOut(o1), .pinOe(e1), .pinLevel(p1));
  csr_pin_pullup i_pin2 (.pinOut(o2), .pinOe(e2), .pinLevel(p2));
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    return v ^ (v << 5);
  endfunction
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick();
    @(posedge mclk);
    #1;
  endtask
  task automatic access(input logic w, input logic [7:0] x,
      input logic [7:0] d);
    wrS = w;
    rdS = !w;
    ad = x;
    wd = d;
    tick();
    wrS = 0;
    rdS = 0;
    tick();
  endtask
  task automatic outs();
    int b = regs[1];
    tick();
    check({bc, en, bb}, regs[0]);
    check({1'b0, ba, 1'b0, bk}, b & 8'h77);
    check(p1, au1 ? !lo1 : b[7]);
    check(p2, au2 ? !lo2 : b[3]);
  endtask
  task automatic end_sim();
    if (miscompares == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    mclk = 0;
    forever #2.5 mclk = ~mclk;
  end
  initial begin
    {rst, wrS, rdS, ad, wd, au1, au2, lo1, lo2} = 23'h400000;
    repeat (12) @(posedge mclk);
    #1 rst = 0;
    outs();
    for (int i = 0; i < 80; i++) begin
      seed = xs(seed);
      a = 8'h03 + seed[1:0];
      if (seed[2]) begin
        access(1, a, seed[15:8]);
        if (a == 4 || a == 5) regs[a - 4] = seed[15:8];
      end else begin
        access(0, a, 8'h00);
        check(rd, (a == 4 || a == 5) ? regs[a - 4] : 0);
      end
      {au1, au2, lo1, lo2} = seed[19:16];
      outs();
    end
    end_sim();
  end
endmodule
